// ===== rtl/mpc_pkg.sv
package mpc_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int LANE_W = 4;
	localparam int SETUP_W = 6;
	localparam int FWD_W = 7;
	localparam int IDENT_W = 96;
	localparam logic [15:0] OFS_REVISION = 16'h0300;
	localparam logic [15:0] OFS_SCRATCH = 16'h0301;
	localparam logic [15:0] OFS_IDENT0 = 16'h0302;
	localparam logic [15:0] OFS_IDENT1 = 16'h0303;
	localparam logic [15:0] OFS_IDENT2 = 16'h0304;
	localparam logic [15:0] OFS_SETUP = 16'h0310;
	localparam logic [15:0] OFS_TX_CNT_SETUP = 16'h0845;
	localparam logic [15:0] OFS_TX_CNT_STATE = 16'h0846;
	localparam logic [15:0] OFS_RX_CNT_SETUP = 16'h0945;
	localparam logic [15:0] OFS_RX_CNT_STATE = 16'h0946;
	localparam logic [15:0] TXS_A_LO = 16'h0800;
	localparam logic [15:0] TXS_A_HI = 16'h0837;
	localparam logic [15:0] TXS_B_LO = 16'h0860;
	localparam logic [15:0] TXS_B_HI = 16'h0861;
	localparam logic [15:0] RXS_A_LO = 16'h0900;
	localparam logic [15:0] RXS_A_HI = 16'h0937;
	localparam logic [15:0] RXS_B_LO = 16'h0960;
	localparam logic [15:0] RXS_B_HI = 16'h0961;
	localparam logic [15:0] TXPTP_LO = 16'h0A00;
	localparam logic [15:0] TXPTP_HI = 16'h0A0C;
	localparam logic [15:0] RXPTP_LO = 16'h0B00;
	localparam logic [15:0] RXPTP_HI = 16'h0B06;
	localparam logic [15:0] TXFEC_LO = 16'h0C00;
	localparam logic [15:0] TXFEC_HI = 16'h0C07;
	localparam logic [15:0] RXFEC_LO = 16'h0D00;
	localparam logic [15:0] RXFEC_HI = 16'h0D08;
	localparam int LANE_LSB = 10;
	localparam logic [3:0] XCVR4_TAG = 4'h4;
	localparam logic [1:0] XCVR10_TAG = 2'h1;
	localparam int LANES_DEFAULT = 10;
	localparam int SETUP_SYS_RST = 0;
	localparam int SETUP_LOCK_DATA = 5;
	localparam int FSEL_TXSTAT = 0;
	localparam int FSEL_RXSTAT = 1;
	localparam int FSEL_TXPTP = 2;
	localparam int FSEL_RXPTP = 3;
	localparam logic [5:0] SETUP_RESET = 6'h00;
	localparam logic [31:0] SCRATCH_RESET = 32'h00000000;
	localparam logic [31:0] CNT_SETUP_RESET = 32'h00000000;
	localparam logic [31:0] RESERVED_READ = 32'h00000000;
	// Arbitrary value
	localparam logic [31:0] REVISION_DEFAULT = 32'h0001A5C3;
	// Arbitrary value, first character in the top byte
	localparam logic [95:0] IDENT_DEFAULT = 96'h637372206D61702064656D6F;

	typedef enum logic [8:0] {
		RG_RESERVED = 9'h001,
		RG_LOCAL = 9'h002,
		RG_TXSTAT = 9'h004,
		RG_RXSTAT = 9'h008,
		RG_TXPTP = 9'h010,
		RG_RXPTP = 9'h020,
		RG_TXFEC = 9'h040,
		RG_RXFEC = 9'h080,
		RG_XCVR = 9'h100
	} mpc_region_e;

	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_FWD = 3'h2,
		ST_DONE = 3'h4
	} mpc_fsm_e;

	typedef struct packed {
		mpc_fsm_e state;
		logic waitReq;
		logic readValid;
		logic [DATA_W-1:0] readData;
		logic [FWD_W-1:0] fwdSel;
		logic fwdRead;
		logic fwdWrite;
		logic [ADDR_W-1:0] fwdAddress;
		logic [LANE_W-1:0] fwdLane;
		logic [DATA_W-1:0] fwdWriteData;
		logic [DATA_W-1:0] scratch;
		logic [SETUP_W-1:0] setup;
		logic resetStart;
		logic [DATA_W-1:0] txSetup;
		logic [DATA_W-1:0] rxSetup;
	} mpc_state_s;
endpackage : mpc_pkg

// ===== rtl/mpc_addr_decode.sv
`timescale 1ns/1ps
module mpc_addr_decode #(
	parameter bit EN_TX_STATS = 1'b1,
	parameter bit EN_RX_STATS = 1'b1,
	parameter bit EN_PTP = 1'b1,
	parameter bit EN_RSFEC = 1'b1,
	parameter int unsigned LANES = mpc_pkg::LANES_DEFAULT
) (
	input wire logic [mpc_pkg::ADDR_W-1:0] address,
	output mpc_pkg::mpc_region_e region,
	output logic [mpc_pkg::LANE_W-1:0] lane
);
	function automatic logic inRange(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : inRange

	always_comb begin
		region = mpc_pkg::RG_RESERVED;
		lane = 4'h0;
		if (inRange(address, mpc_pkg::OFS_REVISION, mpc_pkg::OFS_IDENT2) || address == mpc_pkg::OFS_SETUP) begin
			region = mpc_pkg::RG_LOCAL;
		end else if (EN_TX_STATS && inRange(address, mpc_pkg::OFS_TX_CNT_SETUP, mpc_pkg::OFS_TX_CNT_STATE)) begin
			region = mpc_pkg::RG_LOCAL;
		end else if (EN_RX_STATS && inRange(address, mpc_pkg::OFS_RX_CNT_SETUP, mpc_pkg::OFS_RX_CNT_STATE)) begin
			region = mpc_pkg::RG_LOCAL;
		end else if (EN_TX_STATS && (inRange(address, mpc_pkg::TXS_A_LO, mpc_pkg::TXS_A_HI)
				|| inRange(address, mpc_pkg::TXS_B_LO, mpc_pkg::TXS_B_HI))) begin
			region = mpc_pkg::RG_TXSTAT;
		end else if (EN_RX_STATS && (inRange(address, mpc_pkg::RXS_A_LO, mpc_pkg::RXS_A_HI)
				|| inRange(address, mpc_pkg::RXS_B_LO, mpc_pkg::RXS_B_HI))) begin
			region = mpc_pkg::RG_RXSTAT;
		end else if (EN_PTP && inRange(address, mpc_pkg::TXPTP_LO, mpc_pkg::TXPTP_HI)) begin
			region = mpc_pkg::RG_TXPTP;
		end else if (EN_PTP && inRange(address, mpc_pkg::RXPTP_LO, mpc_pkg::RXPTP_HI)) begin
			region = mpc_pkg::RG_RXPTP;
		end else if (EN_RSFEC && inRange(address, mpc_pkg::TXFEC_LO, mpc_pkg::TXFEC_HI)) begin
			region = mpc_pkg::RG_TXFEC;
		end else if (EN_RSFEC && inRange(address, mpc_pkg::RXFEC_LO, mpc_pkg::RXFEC_HI)) begin
			region = mpc_pkg::RG_RXFEC;
		end else if (LANES == 4 && address[15:12] == mpc_pkg::XCVR4_TAG) begin
			region = mpc_pkg::RG_XCVR;
			lane = {2'h0, address[mpc_pkg::LANE_LSB +: 2]};
		end else if (LANES == 10 && address[15:14] == mpc_pkg::XCVR10_TAG
				&& address[mpc_pkg::LANE_LSB +: 4] < 4'(LANES)) begin
			region = mpc_pkg::RG_XCVR;
			lane = address[mpc_pkg::LANE_LSB +: 4];
		end
	end
endmodule : mpc_addr_decode

// ===== rtl/mpc_csr_map.sv
`timescale 1ns/1ps
// Notes on behaviour
// - TX statistics ranges 0x800-0x837, 0x860-0x861 decode only when TX statistics built.
// - TX counter setup at 0x845, TX counter state at 0x846, only with TX statistics.
// - RX statistics ranges 0x900-0x937, 0x960-0x961 decode only when RX statistics built.
// - RX counter setup at 0x945, RX counter state at 0x946, only with RX statistics.
// - TX timestamping words 0xA00-0xA0C reachable only when timestamping is built.
// - RX timestamping words 0xB00-0xB06 reachable only when timestamping is built.
// - Four lanes: transceiver window from 0x4000, 0x400 per lane, bits 11:10 pick lane.
// - Ten lanes: bits 13:10 pick lane, lane block at 0x4000 plus lane times 0x400.
// - Word 0x300 returns a fixed 32-bit revision code and ignores writes.
// - Word 0x301 is a 32-bit scratch word, zero after reset, reads last write.
// - Words 0x302-0x304 read four characters each of a twelve-character identifier.
// - Setup word 0x310 bit 5 makes the receive PLL lock to data; resets to zero.
// - Each port address selects one whole 32-bit word; no byte addressing.
// - Writes to read-only or reserved words do nothing; reserved reads return a constant.
// - Setting setup word bit 0 starts the transceiver reset sequence.
module mpc_csr_map #(
	parameter bit EN_TX_STATS = 1'b1,
	parameter bit EN_RX_STATS = 1'b1,
	parameter bit EN_PTP = 1'b1,
	parameter bit EN_RSFEC = 1'b1,
	parameter int unsigned LANES = mpc_pkg::LANES_DEFAULT,
	parameter logic [31:0] REVISION_CODE = mpc_pkg::REVISION_DEFAULT,
	parameter logic [95:0] IDENT_STRING = mpc_pkg::IDENT_DEFAULT
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic clockEnable,
	input wire logic [mpc_pkg::ADDR_W-1:0] statusAddress,
	input wire logic statusRead,
	input wire logic statusWrite,
	input wire logic [mpc_pkg::DATA_W-1:0] statusWriteData,
	output logic [mpc_pkg::DATA_W-1:0] statusReadData,
	output logic statusReadDataValid,
	output logic statusWaitRequest,
	output logic [mpc_pkg::FWD_W-1:0] fwdSelect,
	output logic fwdRead,
	output logic fwdWrite,
	output logic [mpc_pkg::ADDR_W-1:0] fwdAddress,
	output logic [mpc_pkg::LANE_W-1:0] fwdLane,
	output logic [mpc_pkg::DATA_W-1:0] fwdWriteData,
	input wire logic [mpc_pkg::DATA_W-1:0] fwdReadData,
	output logic [mpc_pkg::DATA_W-1:0] txCounterSetup,
	input wire logic [mpc_pkg::DATA_W-1:0] txCounterState,
	output logic [mpc_pkg::DATA_W-1:0] rxCounterSetup,
	input wire logic [mpc_pkg::DATA_W-1:0] rxCounterState,
	output logic [mpc_pkg::SETUP_W-1:0] phySetupControl,
	output logic phyLockToData,
	output logic phyResetStart
);
	localparam mpc_pkg::mpc_state_s ST_RESET = '{
		state: mpc_pkg::ST_IDLE,
		waitReq: 1'b0,
		readValid: 1'b0,
		readData: 32'h00000000,
		fwdSel: 7'h00,
		fwdRead: 1'b0,
		fwdWrite: 1'b0,
		fwdAddress: 16'h0000,
		fwdLane: 4'h0,
		fwdWriteData: 32'h00000000,
		scratch: mpc_pkg::SCRATCH_RESET,
		setup: mpc_pkg::SETUP_RESET,
		resetStart: 1'b0,
		txSetup: mpc_pkg::CNT_SETUP_RESET,
		rxSetup: mpc_pkg::CNT_SETUP_RESET
	};

	mpc_pkg::mpc_state_s st_reg;
	mpc_pkg::mpc_state_s st_next;
	mpc_pkg::mpc_region_e regionNow;
	logic [mpc_pkg::LANE_W-1:0] laneNow;
	logic [mpc_pkg::DATA_W-1:0] localData;
	logic accept;

	mpc_addr_decode #(
		.EN_TX_STATS(EN_TX_STATS),
		.EN_RX_STATS(EN_RX_STATS),
		.EN_PTP(EN_PTP),
		.EN_RSFEC(EN_RSFEC),
		.LANES(LANES)
	) u_decode (
		.address(statusAddress),
		.region(regionNow),
		.lane(laneNow)
	);

	// Requests are only looked at in idle, so waitrequest is honest
	assign accept = clockEnable && (st_reg.state == mpc_pkg::ST_IDLE) && (statusRead || statusWrite);

	// Whole-word read mux, nothing below word granularity
	always_comb begin
		localData = mpc_pkg::RESERVED_READ;
		case (statusAddress)
			mpc_pkg::OFS_REVISION: begin
				localData = REVISION_CODE;
			end
			mpc_pkg::OFS_SCRATCH: begin
				localData = st_reg.scratch;
			end
			mpc_pkg::OFS_IDENT0: begin
				localData = IDENT_STRING[95:64];
			end
			mpc_pkg::OFS_IDENT1: begin
				localData = IDENT_STRING[63:32];
			end
			mpc_pkg::OFS_IDENT2: begin
				localData = IDENT_STRING[31:0];
			end
			mpc_pkg::OFS_SETUP: begin
				localData = {26'h0000000, st_reg.setup};
			end
			mpc_pkg::OFS_TX_CNT_SETUP: begin
				localData = EN_TX_STATS ? st_reg.txSetup : mpc_pkg::RESERVED_READ;
			end
			mpc_pkg::OFS_TX_CNT_STATE: begin
				localData = EN_TX_STATS ? txCounterState : mpc_pkg::RESERVED_READ;
			end
			mpc_pkg::OFS_RX_CNT_SETUP: begin
				localData = EN_RX_STATS ? st_reg.rxSetup : mpc_pkg::RESERVED_READ;
			end
			mpc_pkg::OFS_RX_CNT_STATE: begin
				localData = EN_RX_STATS ? rxCounterState : mpc_pkg::RESERVED_READ;
			end
			default: begin
				localData = mpc_pkg::RESERVED_READ;
			end
		endcase
	end

	always_comb begin
		st_next = st_reg;
		st_next.resetStart = 1'b0;
		case (st_reg.state)
			mpc_pkg::ST_IDLE: begin
				if (statusRead || statusWrite) begin
					st_next.waitReq = 1'b1;
					if (regionNow == mpc_pkg::RG_LOCAL || regionNow == mpc_pkg::RG_RESERVED) begin
						// Reserved and disabled words finish like local ones
						st_next.state = mpc_pkg::ST_DONE;
						if (statusRead) begin
							st_next.readValid = 1'b1;
							st_next.readData = localData;
						end
						if (statusWrite && regionNow == mpc_pkg::RG_LOCAL) begin
							case (statusAddress)
								mpc_pkg::OFS_SCRATCH: begin
									st_next.scratch = statusWriteData;
								end
								mpc_pkg::OFS_SETUP: begin
									st_next.setup = statusWriteData[mpc_pkg::SETUP_W-1:0];
									st_next.resetStart = statusWriteData[mpc_pkg::SETUP_SYS_RST];
								end
								mpc_pkg::OFS_TX_CNT_SETUP: begin
									st_next.txSetup = statusWriteData;
								end
								mpc_pkg::OFS_RX_CNT_SETUP: begin
									st_next.rxSetup = statusWriteData;
								end
								default: begin
									// Read-only words keep their value
									st_next.scratch = st_reg.scratch;
								end
							endcase
						end
					end else begin
						st_next.state = mpc_pkg::ST_FWD;
						st_next.fwdSel = regionNow[8:2];
						st_next.fwdRead = statusRead;
						st_next.fwdWrite = statusWrite;
						st_next.fwdAddress = statusAddress;
						st_next.fwdLane = laneNow;
						st_next.fwdWriteData = statusWriteData;
					end
				end
			end
			mpc_pkg::ST_FWD: begin
				// Feature blocks answer in the strobe cycle; read data is taken as the strobe drops
				st_next.state = mpc_pkg::ST_DONE;
				st_next.fwdSel = 7'h00;
				st_next.fwdRead = 1'b0;
				st_next.fwdWrite = 1'b0;
				if (st_reg.fwdRead) begin
					st_next.readValid = 1'b1;
					st_next.readData = fwdReadData;
				end
			end
			mpc_pkg::ST_DONE: begin
				st_next.state = mpc_pkg::ST_IDLE;
				st_next.readValid = 1'b0;
				st_next.waitReq = 1'b0;
			end
			default: begin
				st_next.state = mpc_pkg::ST_IDLE;
				st_next.readValid = 1'b0;
				st_next.waitReq = 1'b0;
				st_next.fwdSel = 7'h00;
				st_next.fwdRead = 1'b0;
				st_next.fwdWrite = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			st_reg <= ST_RESET;
		end else if (clockEnable) begin
			st_reg <= st_next;
		end
	end

	assign statusReadData = st_reg.readData;
	assign statusReadDataValid = st_reg.readValid;
	assign statusWaitRequest = st_reg.waitReq;
	assign fwdSelect = st_reg.fwdSel;
	assign fwdRead = st_reg.fwdRead;
	assign fwdWrite = st_reg.fwdWrite;
	assign fwdAddress = st_reg.fwdAddress;
	assign fwdLane = st_reg.fwdLane;
	assign fwdWriteData = st_reg.fwdWriteData;
	assign txCounterSetup = st_reg.txSetup;
	assign rxCounterSetup = st_reg.rxSetup;
	assign phySetupControl = st_reg.setup;
	assign phyLockToData = st_reg.setup[mpc_pkg::SETUP_LOCK_DATA];
	assign phyResetStart = st_reg.resetStart;

	// Checks assume the clock enable stays high across a transfer
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset || !clockEnable);

	sequence s_local_reply;
		##1 (statusReadDataValid && statusWaitRequest && !fwdRead)
		##1 (!statusReadDataValid && !statusWaitRequest);
	endsequence

	sequence s_fwd_reply;
		##1 (fwdRead && statusWaitRequest && !statusReadDataValid)
		##1 (!fwdRead && statusReadDataValid && statusWaitRequest)
		##1 (!statusReadDataValid && !statusWaitRequest);
	endsequence

	a_revision_read: assert property (
		accept && statusRead && statusAddress == mpc_pkg::OFS_REVISION
		|-> ##1 (statusReadData == REVISION_CODE)
	) else $error("revision word read wrong");

	a_scratch_echo: assert property (
		accept && statusWrite && statusAddress == mpc_pkg::OFS_SCRATCH
		|=> (st_reg.scratch == $past(statusWriteData)) ##1 (st_reg.scratch == $past(statusWriteData, 2))
	) else $error("scratch word lost its value");

	a_ident_middle: assert property (
		accept && statusRead && statusAddress == mpc_pkg::OFS_IDENT1
		|=> statusReadDataValid && (statusReadData == IDENT_STRING[63:32])
	) else $error("identifier middle word wrong");

	a_ident_first: assert property (
		accept && statusRead && statusAddress == mpc_pkg::OFS_IDENT0
		|=> (statusReadData == IDENT_STRING[95:64])
	) else $error("identifier first word wrong");

	a_lock_data: assert property (
		accept && statusWrite && statusAddress == mpc_pkg::OFS_SETUP
		|=> (phyLockToData == $past(statusWriteData[mpc_pkg::SETUP_LOCK_DATA]))
	) else $error("lock to data bit not taken");

	a_reset_pulse: assert property (
		accept && statusWrite && statusAddress == mpc_pkg::OFS_SETUP && statusWriteData[0]
		|=> phyResetStart ##1 !phyResetStart
	) else $error("reset start pulse wrong");

	a_tx_stats_gate: assert property (
		accept && statusAddress >= mpc_pkg::TXS_A_LO && statusAddress <= mpc_pkg::TXS_A_HI
		|=> (fwdSelect[mpc_pkg::FSEL_TXSTAT] == EN_TX_STATS)
	) else $error("tx statistics decode wrong");

	a_rx_stats_gate: assert property (
		accept && statusAddress >= mpc_pkg::RXS_B_LO && statusAddress <= mpc_pkg::RXS_B_HI
		|=> (fwdSelect[mpc_pkg::FSEL_RXSTAT] == EN_RX_STATS)
	) else $error("rx statistics decode wrong");

	a_ptp_gate: assert property (
		accept && statusAddress >= mpc_pkg::TXPTP_LO && statusAddress <= mpc_pkg::TXPTP_HI
		|=> (fwdSelect[mpc_pkg::FSEL_TXPTP] == EN_PTP)
	) else $error("tx timestamp decode wrong");

	a_tx_setup_write: assert property (
		accept && statusWrite && statusAddress == mpc_pkg::OFS_TX_CNT_SETUP
		|=> (txCounterSetup == (EN_TX_STATS ? $past(statusWriteData) : $past(txCounterSetup)))
	) else $error("tx counter setup write wrong");

	a_lane_pick: assert property (
		accept && regionNow == mpc_pkg::RG_XCVR
		|=> fwdSelect == 7'h40 && (fwdLane == $past(statusAddress[13:10]))
	) else $error("transceiver lane pick wrong");

	a_fwd_read: assert property (
		accept && statusRead && regionNow != mpc_pkg::RG_LOCAL && regionNow != mpc_pkg::RG_RESERVED
		|-> s_fwd_reply
	) else $error("forwarded read sequence wrong");

	a_reserved_nostall: assert property (
		accept && statusRead && regionNow == mpc_pkg::RG_RESERVED
		|-> s_local_reply
	) else $error("reserved read stalled");

	a_reserved_value: assert property (
		accept && statusRead && regionNow == mpc_pkg::RG_RESERVED
		|=> (statusReadData == mpc_pkg::RESERVED_READ) && (fwdSelect == 7'h00)
	) else $error("reserved read value wrong");

	a_rx_setup_write: assert property (
		accept && statusWrite && statusAddress == mpc_pkg::OFS_RX_CNT_SETUP
		|=> (rxCounterSetup == (EN_RX_STATS ? $past(statusWriteData) : $past(rxCounterSetup)))
	) else $error("rx counter setup write wrong");

	a_tx_state_read: assert property (
		accept && statusRead && statusAddress == mpc_pkg::OFS_TX_CNT_STATE
		|=> (statusReadData == (EN_TX_STATS ? $past(txCounterState) : mpc_pkg::RESERVED_READ))
	) else $error("tx counter state read wrong");

	a_rxptp_gate: assert property (
		accept && statusAddress >= mpc_pkg::RXPTP_LO && statusAddress <= mpc_pkg::RXPTP_HI
		|=> (fwdSelect[mpc_pkg::FSEL_RXPTP] == EN_PTP)
	) else $error("rx timestamp decode wrong");

	a_lane_four: assert property (
		accept && regionNow == mpc_pkg::RG_XCVR && LANES == 4
		|=> (fwdLane == {2'h0, $past(statusAddress[11:10])})
	) else $error("four lane pick wrong");

	a_fwd_write: assert property (
		accept && statusWrite && regionNow != mpc_pkg::RG_LOCAL && regionNow != mpc_pkg::RG_RESERVED
		|=> fwdWrite && (fwdWriteData == $past(statusWriteData)) && (fwdAddress == $past(statusAddress))
	) else $error("forwarded write wrong");

	a_ident_last: assert property (
		accept && statusRead && statusAddress == mpc_pkg::OFS_IDENT2
		|=> (statusReadData == IDENT_STRING[31:0])
	) else $error("identifier last word wrong");

endmodule : mpc_csr_map

// ===== test/mpc_csr_map_tb.sv
`timescale 1ns/1ps
module mpc_csr_map_tb;
	typedef struct {bit b; logic [15:0] a; int op; logic [31:0] d; logic [31:0] x; logic [6:0] s;
		logic [3:0] l; int w;} mpc_row_s;
	localparam int RD = 1;
	localparam int WR = 2;
	// Marker for no read data seen
	localparam logic [31:0] NV = 32'hDEADBEEF;
	localparam logic [31:0] REV = mpc_pkg::REVISION_DEFAULT;
	logic clock, reset, clockEnable, statusRead, statusWrite, readB, writeB;
	logic [15:0] statusAddress, fwdAddress;
	logic [31:0] statusWriteData, fwdReadData, txCounterState, rxCounterState;
	logic [31:0] statusReadData, rdB, txCounterSetup, rxCounterSetup, fwdWriteData;
	logic statusReadDataValid, statusWaitRequest, validB, waitB, fwdRead, fwdWrite, phyLockToData, phyResetStart;
	logic [6:0] fwdSelect, selB;
	logic [3:0] fwdLane, laneB;
	logic [5:0] phySetupControl;
	logic [31:0] gotData;
	logic [6:0] gotSel;
	logic [3:0] gotLane;
	int gotWait;
	int n_errors = 0;
	int n_compared = 0;
	int nPulse = 0;
	int cycles = 0;
	mpc_row_s rows[$];

	mpc_csr_map i_mpc_csr_map (.clock, .reset, .clockEnable, .statusAddress, .statusRead, .statusWrite,
		.statusWriteData, .statusReadData, .statusReadDataValid, .statusWaitRequest, .fwdSelect, .fwdRead,
		.fwdWrite, .fwdAddress, .fwdLane, .fwdWriteData, .fwdReadData, .txCounterSetup, .txCounterState,
		.rxCounterSetup, .rxCounterState, .phySetupControl, .phyLockToData, .phyResetStart);

	// Every option off, four lanes: shows what a bare build answers
	mpc_csr_map #(.EN_TX_STATS(1'h0), .EN_RX_STATS(1'h0), .EN_PTP(1'h0), .EN_RSFEC(1'h0), .LANES(4))
		i_mpc_csr_map_bare (.clock, .reset, .clockEnable, .statusAddress, .statusRead(readB),
		.statusWrite(writeB), .statusWriteData, .statusReadData(rdB), .statusReadDataValid(validB),
		.statusWaitRequest(waitB), .fwdSelect(selB), .fwdRead(), .fwdWrite(), .fwdAddress(), .fwdLane(laneB),
		.fwdWriteData(), .fwdReadData, .txCounterSetup(), .txCounterState, .rxCounterSetup(), .rxCounterState,
		.phySetupControl(), .phyLockToData(), .phyResetStart());

	initial begin
		clock = 1'h0;
		forever #12.5 clock = ~clock;
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Compared %0d, errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error %0t: addr %h seen %h expected %h", $time, statusAddress, seen, exp);
		end
	endtask : check

	// One access, taken at the first edge since the port is idle between calls
	task automatic xfer(input bit b, input logic [15:0] a, input int op, input logic [31:0] d);
		int k;
		@(posedge clock);
		statusAddress <= a;
		statusWriteData <= d;
		fwdReadData <= {16'hF00D, a};
		readB <= b & op[0];
		writeB <= b & op[1];
		statusRead <= !b & op[0];
		statusWrite <= !b & op[1];
		@(posedge clock);
		statusRead <= 1'h0;
		statusWrite <= 1'h0;
		readB <= 1'h0;
		writeB <= 1'h0;
		gotData = NV;
		gotSel = 7'h00;
		gotLane = 4'hF;
		gotWait = 0;
		for (k = 0; k < 6; k++) begin
			@(negedge clock);
			if ((b ? validB : statusReadDataValid) === 1'h1) gotData = b ? rdB : statusReadData;
			if (phyResetStart === 1'h1) nPulse++;
			if ((b ? selB : fwdSelect) !== 7'h00) begin
				gotSel = b ? selB : fwdSelect;
				gotLane = b ? laneB : fwdLane;
				if (!b) check({14'h0000, fwdRead, fwdWrite, fwdAddress}, {14'h0000, op[0], op[1], a});
				if (!b && op == WR) check(fwdWriteData, d);
			end
			if ((b ? waitB : statusWaitRequest) !== 1'h1) break;
			gotWait++;
		end
	endtask : xfer

	function automatic void add(bit b, logic [15:0] a, int op, logic [31:0] d, logic [31:0] x, logic [6:0] s,
		logic [3:0] l, int w);
		rows.push_back('{b, a, op, d, x, s, l, w});
	endfunction : add

	initial begin
		reset = 1'h1;
		clockEnable = 1'h1;
		statusAddress = 16'h0000;
		statusRead = 1'h0;
		statusWrite = 1'h0;
		readB = 1'h0;
		writeB = 1'h0;
		statusWriteData = 32'h00000000;
		fwdReadData = 32'h00000000;
		txCounterState = 32'h7A7A0846;
		rxCounterState = 32'h5B5B0946;
		repeat (10) @(posedge clock);
		reset <= 1'h0;
		add(0, 16'h0301, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0300, WR, 32'hFFFFFFFF, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0300, RD, 32'h0, REV, 7'h00, 4'h0, 1);
		add(0, 16'h0301, WR, 32'hA5A55A5A, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0301, RD, 32'h0, 32'hA5A55A5A, 7'h00, 4'h0, 1);
		add(0, 16'h0302, WR, 32'h0, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0302, RD, 32'h0, mpc_pkg::IDENT_DEFAULT[95:64], 7'h00, 4'h0, 1);
		add(0, 16'h0303, RD, 32'h0, mpc_pkg::IDENT_DEFAULT[63:32], 7'h00, 4'h0, 1);
		add(0, 16'h0304, RD, 32'h0, mpc_pkg::IDENT_DEFAULT[31:0], 7'h00, 4'h0, 1);
		add(0, 16'h0305, WR, 32'hFFFFFFFF, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0305, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0800, RD, 32'h0, 32'hF00D0800, 7'h01, 4'h0, 2);
		add(0, 16'h0837, WR, 32'h12345678, NV, 7'h01, 4'h0, 2);
		add(0, 16'h0838, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0861, RD, 32'h0, 32'hF00D0861, 7'h01, 4'h0, 2);
		add(0, 16'h0862, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0845, WR, 32'h0000C0FE, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0845, RD, 32'h0, 32'h0000C0FE, 7'h00, 4'h0, 1);
		add(0, 16'h0846, RD, 32'h0, 32'h7A7A0846, 7'h00, 4'h0, 1);
		add(0, 16'h0900, RD, 32'h0, 32'hF00D0900, 7'h02, 4'h0, 2);
		add(0, 16'h0960, RD, 32'h0, 32'hF00D0960, 7'h02, 4'h0, 2);
		add(0, 16'h0938, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0945, WR, 32'h0000BEEF, NV, 7'h00, 4'h0, 1);
		add(0, 16'h0945, RD, 32'h0, 32'h0000BEEF, 7'h00, 4'h0, 1);
		add(0, 16'h0946, RD, 32'h0, 32'h5B5B0946, 7'h00, 4'h0, 1);
		add(0, 16'h0A0C, RD, 32'h0, 32'hF00D0A0C, 7'h04, 4'h0, 2);
		add(0, 16'h0A0D, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0B06, WR, 32'h00000055, NV, 7'h08, 4'h0, 2);
		add(0, 16'h0B07, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(0, 16'h0D08, RD, 32'h0, 32'hF00D0D08, 7'h20, 4'h0, 2);
		add(0, 16'h4000, RD, 32'h0, 32'hF00D4000, 7'h40, 4'h0, 2);
		add(0, 16'h6400, RD, 32'h0, 32'hF00D6400, 7'h40, 4'h9, 2);
		add(0, 16'h6800, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0800, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0845, WR, 32'h0000C0FE, NV, 7'h00, 4'h0, 1);
		add(1, 16'h0845, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0960, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0946, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0A00, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h0B06, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		add(1, 16'h4C00, RD, 32'h0, 32'hF00D4C00, 7'h40, 4'h3, 2);
		add(1, 16'h5000, RD, 32'h0, 32'h0, 7'h00, 4'h0, 1);
		foreach (rows[i]) begin
			xfer(rows[i].b, rows[i].a, rows[i].op, rows[i].d);
			check(gotData, rows[i].x);
			check({25'h0000000, gotSel}, {25'h0000000, rows[i].s});
			check(gotWait, rows[i].w);
			if (rows[i].s[6]) check({28'h0000000, gotLane}, {28'h0000000, rows[i].l});
		end
		check(txCounterSetup, 32'h0000C0FE);
		check(rxCounterSetup, 32'h0000BEEF);
		// Bit 0 and bit 5 together, then each alone
		nPulse = 0;
		xfer(0, 16'h0310, WR, 32'hFFFFFFFF);
		check(nPulse, 1);
		check({26'h0000000, phySetupControl}, 32'h0000003F);
		check({31'h00000000, phyLockToData}, 32'h00000001);
		xfer(0, 16'h0310, RD, 32'h0);
		check(gotData, 32'h0000003F);
		xfer(0, 16'h0310, WR, 32'h00000020);
		check(nPulse, 1);
		xfer(0, 16'h0310, WR, 32'h00000001);
		check(nPulse, 2);
		check({31'h00000000, phyLockToData}, 32'h00000000);
		// Second reset in mid-run clears the writable words
		@(posedge clock);
		reset <= 1'h1;
		repeat (2) @(posedge clock);
		reset <= 1'h0;
		@(negedge clock);
		check({26'h0000000, phySetupControl}, 32'h00000000);
		check(txCounterSetup, 32'h00000000);
		check(rxCounterSetup, 32'h00000000);
		// Frozen port: a held write waits until the enable returns
		@(posedge clock);
		clockEnable <= 1'h0;
		statusAddress <= 16'h0310;
		statusWriteData <= 32'h00000020;
		statusWrite <= 1'h1;
		repeat (3) @(posedge clock);
		@(negedge clock);
		check({25'h0000000, statusWaitRequest, phySetupControl}, 32'h00000000);
		@(posedge clock);
		clockEnable <= 1'h1;
		@(posedge clock);
		statusWrite <= 1'h0;
		@(negedge clock);
		check({26'h0000000, phySetupControl}, 32'h00000020);
		xfer(0, 16'h0301, RD, 32'h0);
		check(gotData, 32'h00000000);
		final_report();
	end
endmodule : mpc_csr_map_tb
